// ### verilog/motor_zone_pkg.sv
`default_nettype none
// ============================================================
// shared constants and carriers for the motor zone status bank
package motor_zone_pkg;
	// register addresses, as seen by the fieldbus register port
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] OFS_LEFT_SERVO_STATUS = 10'h00B;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_SERVO_STATUS = 10'h010;
	localparam logic [ADDR_W-1:0] OFS_LEFT_PORT_OUTPUT_STATUS = 10'h03C;
	localparam logic [ADDR_W-1:0] OFS_LEFT_SERVO_POSITION = 10'h03E;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_MOTOR_CURRENT = 10'h04F;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_MOTOR_FREQUENCY = 10'h050;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_MOTOR_TEMPERATURES = 10'h051;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_MOTOR_FLAGS = 10'h052;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_PORT_OUTPUT_STATUS = 10'h054;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_SERVO_POSITION = 10'h056;
	localparam logic [ADDR_W-1:0] OFS_UPSTREAM_ZONE_STATE = 10'h086;
	localparam logic [ADDR_W-1:0] OFS_UPSTREAM_TRACKING_WORD_A = 10'h08B;
	localparam logic [ADDR_W-1:0] OFS_UPSTREAM_TRACKING_WORD_B = 10'h08C;
	localparam logic [ADDR_W-1:0] OFS_DOWNSTREAM_ZONE_STATE = 10'h0E8;
	localparam logic [ADDR_W-1:0] OFS_RIGHT_MOTOR_ACTUAL_SPEED = 10'h1FC;
	// ============================================================
	// field positions
	localparam int ROT_LSB = 0;
	localparam int DIGITAL_MODE_BIT = 2;
	localparam int HEALTH_LSB = 5;
	localparam int SPEED_MSB = 13;
	localparam int SPEED_OVER_BIT = 14;
	localparam int SPEED_UNDER_BIT = 15;
	localparam int PORT_SHORT_BIT = 12;
	localparam int PORT_OVERCURRENT_BIT = 14;
	localparam int SERVO_DONE_BIT = 0;
	localparam int SERVO_RESET_ECHO_BIT = 1;
	localparam int SERVO_CMD1_ECHO_BIT = 2;
	localparam int SERVO_CMD_RESET_BIT = 0;
	localparam int SERVO_CMD_BIT1 = 1;
	// ============================================================
	// values and limits
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam int PORT_OUTPUT_LIMIT_MA = 1000;
	localparam logic [7:0] ZONE_CLEAR_STOPPED = 8'h01;
	localparam logic [7:0] ZONE_CLEAR_ACCEPTING = 8'h02;
	localparam logic [7:0] ZONE_BLOCKED_DISCHARGING = 8'h04;
	localparam logic [7:0] ZONE_BLOCKED_STOPPED = 8'h05;
	localparam logic [7:0] ZONE_BUSY = 8'h06;
	// rotation state, two bits of the motor flags word
	typedef enum logic [1:0] {
		ROT_STOPPED = 2'h0,
		ROT_COUNTER_CLOCKWISE = 2'h1,
		ROT_CLOCKWISE = 2'h2,
		ROT_FREE_STOP = 2'h3
	} rotation_type;
	// fault flags, bit 5 up to bit 15 of the motor flags word
	typedef struct packed {
		logic notUsed;
		logic sensorError;
		logic stalled;
		logic overloaded;
		logic notConnected;
		logic shortCircuit;
		logic overCurrent;
		logic motorOverheat;
		logic lowVoltage;
		logic overVoltage;
		logic boardOverheat;
	} motor_health_type;
	// what a neighbour module reports about its zone
	typedef struct packed {
		logic estopActive;
		logic sensorBlocked;
		logic motorRunning;
	} zone_report_type;
	// servo feedback of one motor
	typedef struct packed {
		logic signed [15:0] position;
		logic done;
	} servo_feedback_type;
endpackage
`default_nettype wire

// ### verilog/motor_zone_status_regs.sv
// What this block does
// RL1: report right motor current in milliamperes
// RL2: report right motor electrical frequency in hertz
// RL3: motor temperature high byte, module low
// RL4: flags read-only; bits 0-1 rotation, bit2 digital
// RL5: bits 3-4 reserved; 5,6,7 board/voltage faults
// RL6: bits 8,9,10 overheat, overcurrent, short
// RL7: bits 11-15 unconnected, overload, stall, sensor, unused
// RL8: speed bits 0-13, mm/s or rpm times ten
// RL9: speed bit 14 when command above maximum
// RL10: speed bit 15 when command below minimum
// RL11: port status read-only; bit 12 short
// RL12: port bit 14 when output exceeds 1 A
// RL13: zone code 01 clear stopped, 02 accepting
// RL14: zone code 04 discharging, 05 blocked stopped
// RL15: zone code 06 busy during emergency stop
// RL16: two tracking words of upstream carton
// RL17: neighbour words frozen while links cleared
// RL18: servo position signed, relative to zero
// RL19: servo bit 0 set when run complete
// RL20: servo bit 1 echoes command bit 0
// RL21: servo bit 2 echoes command bit 1
// RL22: rotation 00 stop,01 ccw,10 cw,11 free
// RL23: run speed clamped between minimum and maximum
// RL24: host writes ignored, values unchanged
`timescale 1ns/1ns
`default_nettype none
module motor_zone_status_regs
	import motor_zone_pkg::*;
#(
	parameter int PORT_OUTPUTS = 2 // motor port pins usable as outputs
) (
	input wire logic clk,
	input wire logic rst_b,
	// fieldbus register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [15:0] regWriteData,
	output logic [15:0] regReadData,
	output logic regAck,
	// right motor measurements from firmware
	input wire logic [15:0] currentMa,
	input wire logic [15:0] frequencyHz,
	input wire logic [7:0] motorTempC,
	input wire logic [7:0] moduleTempC,
	input wire rotation_type rotation,
	input wire logic portDigitalMode,
	input wire motor_health_type health,
	input wire logic [SPEED_MSB:0] measuredSpeed,
	input wire logic [15:0] commandedSpeed,
	input wire logic [15:0] motorMaxSpeed,
	input wire logic [15:0] motorMinSpeed,
	// motor port outputs, index 0 left port, 1 right port
	input wire logic [1:0][PORT_OUTPUTS-1:0] outputShort,
	input wire logic [1:0][PORT_OUTPUTS-1:0][15:0] outputCurrentMa,
	// neighbour modules
	input wire logic linksKept,
	input wire logic upstreamUpdate,
	input wire zone_report_type upstreamReport,
	input wire logic [15:0] upstreamTrackA,
	input wire logic [15:0] upstreamTrackB,
	input wire logic downstreamUpdate,
	input wire zone_report_type downstreamReport,
	// servo, index 0 left, 1 right
	input wire servo_feedback_type [1:0] servoFeedback,
	input wire logic [1:0][15:0] servoCommand,
	// speed the motor drive is told to run at
	output logic [15:0] appliedSpeed
);
	// ============================================================
	// stored status words
	logic [15:0] rightCurrent; // milliamperes
	logic [15:0] rightFrequency; // hertz
	logic [15:0] rightTemps; // motor byte over module byte
	logic [15:0] rightFlags; // rotation, mode and fault bits
	logic [15:0] rightSpeed; // measured speed with range flags
	// unpacked so that each generate branch drives its own variable
	logic [15:0] portStatus [2]; // per motor port
	logic [15:0] servoStatus [2]; // per motor
	logic [15:0] servoPosition [2]; // per motor, signed
	logic [15:0] upstreamZone;
	logic [15:0] downstreamZone;
	logic [15:0] trackA;
	logic [15:0] trackB;

	// ============================================================
	// combinational next values
	logic speedOver; // command above motor capability
	logic speedUnder; // command below motor capability
	logic [15:0] next_appliedSpeed;
	logic [15:0] next_rightFlags;
	logic [15:0] next_rightSpeed;
	logic [15:0] next_upstreamZone;
	logic [15:0] next_downstreamZone;
	logic upstreamTake; // neighbour word may be refreshed
	logic downstreamTake;

	// zone code from a neighbour report; busy overrides the sensor
	function automatic logic [7:0] zoneCode(input zone_report_type r);
		logic [7:0] code;
		code = ZONE_CLEAR_STOPPED; // [RL13]
		if (r.estopActive) begin
			code = ZONE_BUSY; // [RL15]
		end else if (r.sensorBlocked) begin
			code = r.motorRunning ? ZONE_BLOCKED_DISCHARGING : ZONE_BLOCKED_STOPPED; // [RL14]
		end else if (r.motorRunning) begin
			code = ZONE_CLEAR_ACCEPTING; // [RL13]
		end
		return code;
	endfunction

	// range check of the set speed against the motor's limits
	assign speedOver = commandedSpeed > motorMaxSpeed; // [RL9]
	assign speedUnder = commandedSpeed < motorMinSpeed; // [RL10]
	// out-of-range commands run at the nearest limit instead of faulting
	assign next_appliedSpeed = speedOver ? motorMaxSpeed : (speedUnder ? motorMinSpeed : commandedSpeed); // [RL23]
	assign next_rightSpeed = {speedUnder, speedOver, measuredSpeed}; // [RL8] [RL9] [RL10]
	// reserved bits 3 and 4 always read zero
	assign next_rightFlags = {health, 2'b00, portDigitalMode, rotation}; // [RL4] [RL5] [RL6] [RL7] [RL22]
	// neighbour words move only while the links are kept
	assign upstreamTake = linksKept && upstreamUpdate; // [RL17]
	assign downstreamTake = linksKept && downstreamUpdate; // [RL17]
	assign next_upstreamZone = {8'h00, zoneCode(upstreamReport)};
	assign next_downstreamZone = {8'h00, zoneCode(downstreamReport)};

	// ============================================================
	// right motor snapshot, refreshed every cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rightCurrent <= RESET_WORD;
			rightFrequency <= RESET_WORD;
			rightTemps <= RESET_WORD;
			rightFlags <= RESET_WORD;
			rightSpeed <= RESET_WORD;
			appliedSpeed <= RESET_WORD;
		end else begin
			rightCurrent <= currentMa; // [RL1]
			rightFrequency <= frequencyHz; // [RL2]
			rightTemps <= {motorTempC, moduleTempC}; // [RL3]
			rightFlags <= next_rightFlags; // [RL4]
			rightSpeed <= next_rightSpeed; // [RL8]
			appliedSpeed <= next_appliedSpeed; // [RL23]
		end
	end

	// ============================================================
	// per-port output checks and per-motor servo words
	genvar m;
	generate
		for (m = 0; m < 2; m++) begin : g_motor
			logic [PORT_OUTPUTS-1:0] overLimit; // output above one ampere
			genvar o;
			for (o = 0; o < PORT_OUTPUTS; o++) begin : g_out
				assign overLimit[o] = outputCurrentMa[m][o] > 16'(PORT_OUTPUT_LIMIT_MA); // [RL12]
			end
			// status words track their sources each cycle
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					portStatus[m] <= RESET_WORD;
					servoStatus[m] <= RESET_WORD;
					servoPosition[m] <= RESET_WORD;
				end else begin
					portStatus[m] <= RESET_WORD;
					portStatus[m][PORT_SHORT_BIT] <= |outputShort[m]; // [RL11]
					portStatus[m][PORT_OVERCURRENT_BIT] <= |overLimit; // [RL12]
					servoStatus[m] <= RESET_WORD;
					servoStatus[m][SERVO_DONE_BIT] <= servoFeedback[m].done; // [RL19]
					servoStatus[m][SERVO_RESET_ECHO_BIT] <= servoCommand[m][SERVO_CMD_RESET_BIT]; // [RL20]
					servoStatus[m][SERVO_CMD1_ECHO_BIT] <= servoCommand[m][SERVO_CMD_BIT1]; // [RL21]
					servoPosition[m] <= servoFeedback[m].position; // [RL18]
				end
			end
		end
	endgenerate

	// ============================================================
	// neighbour zone words, held between updates
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			upstreamZone <= RESET_WORD;
			downstreamZone <= RESET_WORD;
			trackA <= RESET_WORD;
			trackB <= RESET_WORD;
		end else begin
			if (upstreamTake) begin
				upstreamZone <= next_upstreamZone; // [RL13]
				trackA <= upstreamTrackA; // [RL16]
				trackB <= upstreamTrackB; // [RL16]
			end
			if (downstreamTake) begin
				downstreamZone <= next_downstreamZone; // [RL14]
			end
		end
	end

	// ============================================================
	// register port: read decode, writes are answered and dropped
	logic [15:0] readMux;
	always_comb begin
		unique case (regAddr)
			OFS_LEFT_SERVO_STATUS: readMux = servoStatus[0];
			OFS_RIGHT_SERVO_STATUS: readMux = servoStatus[1];
			OFS_LEFT_PORT_OUTPUT_STATUS: readMux = portStatus[0];
			OFS_LEFT_SERVO_POSITION: readMux = servoPosition[0];
			OFS_RIGHT_MOTOR_CURRENT: readMux = rightCurrent;
			OFS_RIGHT_MOTOR_FREQUENCY: readMux = rightFrequency;
			OFS_RIGHT_MOTOR_TEMPERATURES: readMux = rightTemps;
			OFS_RIGHT_MOTOR_FLAGS: readMux = rightFlags;
			OFS_RIGHT_PORT_OUTPUT_STATUS: readMux = portStatus[1];
			OFS_RIGHT_SERVO_POSITION: readMux = servoPosition[1];
			OFS_UPSTREAM_ZONE_STATE: readMux = upstreamZone;
			OFS_UPSTREAM_TRACKING_WORD_A: readMux = trackA;
			OFS_UPSTREAM_TRACKING_WORD_B: readMux = trackB;
			OFS_DOWNSTREAM_ZONE_STATE: readMux = downstreamZone;
			OFS_RIGHT_MOTOR_ACTUAL_SPEED: readMux = rightSpeed;
			// unmapped addresses read as zero
			default: readMux = RESET_WORD;
		endcase
	end

	// answer one cycle after the strobe; write data never reaches a word
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regReadData <= RESET_WORD;
			regAck <= 1'b0;
		end else begin
			regAck <= regRead || regWrite; // [RL24]
			regReadData <= regRead ? readMux : RESET_WORD; // [RL24]
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_current_read: assert property (regRead && regAddr == OFS_RIGHT_MOTOR_CURRENT && $past(rst_b, 2)
		|=> regReadData == $past(currentMa, 2)) else $error("current read mismatch"); // [RL1]
	a_frequency_word: assert property ($past(rst_b) |-> rightFrequency == $past(frequencyHz))
		else $error("frequency word stale"); // [RL2]
	a_temp_bytes: assert property (##1 rightTemps[15:8] == $past(motorTempC) && rightTemps[7:0] == $past(moduleTempC))
		else $error("temperature bytes swapped"); // [RL3]
	a_rotation_bits: assert property (##1 rightFlags[1:0] == $past(rotation) && rightFlags[DIGITAL_MODE_BIT] == $past(portDigitalMode))
		else $error("rotation or mode bits wrong"); // [RL22]
	a_reserved_zero: assert property (rightFlags[4:3] == 2'b00)
		else $error("reserved flag bits set"); // [RL5]
	a_health_bits: assert property (##1 rightFlags[15:HEALTH_LSB] == $past(health))
		else $error("fault flags misplaced"); // [RL7]
	a_speed_over: assert property (commandedSpeed > motorMaxSpeed |=> rightSpeed[SPEED_OVER_BIT] && appliedSpeed == $past(motorMaxSpeed))
		else $error("over-range speed not flagged or clamped"); // [RL9]
	a_speed_under: assert property (commandedSpeed < motorMinSpeed && commandedSpeed <= motorMaxSpeed
		|=> rightSpeed[SPEED_UNDER_BIT] && appliedSpeed == $past(motorMinSpeed))
		else $error("under-range speed not flagged or clamped"); // [RL10]
	a_port_overload: assert property (outputCurrentMa[1][0] > 16'(PORT_OUTPUT_LIMIT_MA) |=> portStatus[1][PORT_OVERCURRENT_BIT])
		else $error("port overcurrent missed"); // [RL12]
	a_zone_busy: assert property (linksKept && upstreamUpdate && upstreamReport.estopActive |=> upstreamZone == 16'h0006)
		else $error("busy code missing"); // [RL15]
	a_links_hold: assert property (!linksKept |=> $stable(upstreamZone) && $stable(trackA) && $stable(downstreamZone))
		else $error("neighbour word moved without links"); // [RL17]
	a_servo_echo: assert property (##1 servoStatus[1][SERVO_RESET_ECHO_BIT] == $past(servoCommand[1][SERVO_CMD_RESET_BIT]))
		else $error("servo reset echo wrong"); // [RL20]
	a_write_ignored: assert property (regWrite && !regRead && !upstreamTake |=> regAck && regReadData == 16'h0000 && $stable(trackB))
		else $error("write disturbed a status word"); // [RL24]

	c_clamp_high: cover property (commandedSpeed > motorMaxSpeed ##1 regRead && regAddr == OFS_RIGHT_MOTOR_ACTUAL_SPEED);
	c_zone_blocked: cover property (upstreamTake && upstreamReport.sensorBlocked && !upstreamReport.estopActive);
	c_servo_done: cover property (!servoFeedback[1].done ##1 servoFeedback[1].done);
	c_write_ack: cover property (regWrite ##1 regAck);
endmodule // motor_zone_status_regs
`default_nettype wire

// ### verif/plc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// fieldbus supervisor stand-in: single-word reads and writes
module plc_host_model
	import motor_zone_pkg::*;
(
	input wire logic clk,
	output logic [ADDR_W-1:0] regAddr,
	output logic regRead,
	output logic regWrite,
	output logic [15:0] regWriteData,
	input wire logic [15:0] regReadData,
	input wire logic regAck
);
	// idle bus from time zero
	initial begin
		regAddr = '0;
		regRead = 1'b0;
		regWrite = 1'b0;
		regWriteData = 16'h0000;
	end
	// one strobe cycle, answer taken in the ack cycle; x when no ack came
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] wd, output logic [15:0] rd);
		@(negedge clk);
		regAddr = a;
		regRead = !wr;
		regWrite = wr;
		regWriteData = wd;
		@(negedge clk);
		// released lines show the inverse, so a stale value cannot pass
		regRead = 1'b0;
		regWrite = 1'b0;
		regAddr = ~a;
		regWriteData = ~wd;
		rd = regAck ? regReadData : 16'hXXXX;
	endtask
endmodule // plc_host_model
`default_nettype wire

// ### verif/motor_zone_status_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module motor_zone_status_regs_tb;
	import motor_zone_pkg::*;
	localparam int P = 2;
	localparam logic [ADDR_W-1:0] MEAS [13] = '{OFS_RIGHT_MOTOR_CURRENT, OFS_RIGHT_MOTOR_FREQUENCY,
		OFS_RIGHT_MOTOR_TEMPERATURES, OFS_RIGHT_MOTOR_FLAGS, OFS_RIGHT_MOTOR_ACTUAL_SPEED,
		OFS_LEFT_PORT_OUTPUT_STATUS, OFS_RIGHT_PORT_OUTPUT_STATUS, OFS_LEFT_SERVO_POSITION,
		OFS_RIGHT_SERVO_POSITION, OFS_LEFT_SERVO_STATUS, OFS_RIGHT_SERVO_STATUS, OFS_UPSTREAM_ZONE_STATE, 10'h3FF};
	// ============================================================
	// stimulus and observed signals
	logic clk = 1'b0, rst_b = 1'b0, regRead, regWrite, regAck, portDigitalMode = 1'b0, linksKept = 1'b0;
	logic upstreamUpdate = 1'b0, downstreamUpdate = 1'b0;
	logic [ADDR_W-1:0] regAddr;
	logic [15:0] regWriteData, regReadData, appliedSpeed, rd;
	logic [15:0] currentMa = '0, frequencyHz = '0, commandedSpeed = '0, motorMaxSpeed = '0, motorMinSpeed = '0;
	logic [15:0] upstreamTrackA = '0, upstreamTrackB = '0;
	logic [7:0] motorTempC = '0, moduleTempC = '0, upZone = '0, dnZone = '0;
	logic [15:0] trA = '0, trB = '0; // expected tracking words
	rotation_type rotation = ROT_STOPPED;
	motor_health_type health = '0;
	logic [SPEED_MSB:0] measuredSpeed = '0;
	logic [1:0][P-1:0] outputShort = '0;
	logic [1:0][P-1:0][15:0] outputCurrentMa = '0;
	zone_report_type upstreamReport = '0, downstreamReport = '0;
	servo_feedback_type [1:0] servoFeedback = '0;
	logic [1:0][15:0] servoCommand = '0;
	integer seed = 32'h12180F79, err_count = 0, samples_checked = 0;
	always #5 clk = ~clk;
	motor_zone_status_regs #(.PORT_OUTPUTS(P)) u_motor_zone_status_regs (.clk(clk), .rst_b(rst_b),
		.regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData),
		.regReadData(regReadData), .regAck(regAck), .currentMa(currentMa), .frequencyHz(frequencyHz),
		.motorTempC(motorTempC), .moduleTempC(moduleTempC), .rotation(rotation), .portDigitalMode(portDigitalMode),
		.health(health), .measuredSpeed(measuredSpeed), .commandedSpeed(commandedSpeed),
		.motorMaxSpeed(motorMaxSpeed), .motorMinSpeed(motorMinSpeed), .outputShort(outputShort),
		.outputCurrentMa(outputCurrentMa), .linksKept(linksKept), .upstreamUpdate(upstreamUpdate),
		.upstreamReport(upstreamReport), .upstreamTrackA(upstreamTrackA), .upstreamTrackB(upstreamTrackB),
		.downstreamUpdate(downstreamUpdate), .downstreamReport(downstreamReport),
		.servoFeedback(servoFeedback), .servoCommand(servoCommand), .appliedSpeed(appliedSpeed));
	plc_host_model u_plc_host_model (.clk(clk), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
		.regWriteData(regWriteData), .regReadData(regReadData), .regAck(regAck));
	// ============================================================
	// expectation helpers
	function automatic logic [7:0] zone_code(input zone_report_type r);
		if (r.estopActive) return ZONE_BUSY; // emergency stop wins over sensor state
		if (r.sensorBlocked) return r.motorRunning ? ZONE_BLOCKED_DISCHARGING : ZONE_BLOCKED_STOPPED;
		return r.motorRunning ? ZONE_CLEAR_ACCEPTING : ZONE_CLEAR_STOPPED;
	endfunction
	function automatic logic [15:0] expect_word(input logic [ADDR_W-1:0] a);
		logic [1:0] over;
		over = '0;
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < P; k++) over[p] |= (outputCurrentMa[p][k] > 16'(PORT_OUTPUT_LIMIT_MA)); // above one amp
		end
		case (a)
			OFS_RIGHT_MOTOR_CURRENT: return currentMa;
			OFS_RIGHT_MOTOR_FREQUENCY: return frequencyHz;
			OFS_RIGHT_MOTOR_TEMPERATURES: return {motorTempC, moduleTempC};
			OFS_RIGHT_MOTOR_FLAGS: return {health, 2'b00, portDigitalMode, rotation};
			OFS_RIGHT_MOTOR_ACTUAL_SPEED: return {commandedSpeed < motorMinSpeed, commandedSpeed > motorMaxSpeed, measuredSpeed};
			OFS_LEFT_PORT_OUTPUT_STATUS: return {1'b0, over[0], 1'b0, |outputShort[0], 12'h000};
			OFS_RIGHT_PORT_OUTPUT_STATUS: return {1'b0, over[1], 1'b0, |outputShort[1], 12'h000};
			OFS_LEFT_SERVO_POSITION: return servoFeedback[0].position;
			OFS_RIGHT_SERVO_POSITION: return servoFeedback[1].position;
			OFS_LEFT_SERVO_STATUS: return {13'h0000, servoCommand[0][1:0], servoFeedback[0].done};
			OFS_RIGHT_SERVO_STATUS: return {13'h0000, servoCommand[1][1:0], servoFeedback[1].done};
			OFS_UPSTREAM_ZONE_STATE: return {8'h00, upZone};
			OFS_UPSTREAM_TRACKING_WORD_A: return trA;
			OFS_UPSTREAM_TRACKING_WORD_B: return trB;
			OFS_DOWNSTREAM_ZONE_STATE: return {8'h00, dnZone};
			default: return 16'h0000; // unmapped reads answer zero
		endcase
	endfunction
	// compare and count; prints one line on a mismatch
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	// neighbour update pulse; tracking lines released to the inverse afterwards
	task automatic neighbour(input logic up, input zone_report_type r, input logic [15:0] a, input logic [15:0] b);
		@(negedge clk);
		upstreamUpdate = up;
		downstreamUpdate = !up;
		upstreamReport = r;
		downstreamReport = r;
		upstreamTrackA = a;
		upstreamTrackB = b;
		@(negedge clk);
		upstreamUpdate = 1'b0;
		downstreamUpdate = 1'b0;
		upstreamReport = ~r;
		downstreamReport = ~r;
		upstreamTrackA = ~a;
		upstreamTrackB = ~b;
	endtask
	// ends the run in one place
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ============================================================
	// watchdog: the tests need well under 2000 cycles
	initial begin
		#200000;
		err_count++;
		summarize();
	end
	// ============================================================
	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		chk("ack in reset", 16'h0000, {15'h0000, regAck});
		rst_b = 1'b1;
		// random measurements, with speed and current near their limits
		for (int n = 0; n < 24; n++) begin
			@(negedge clk);
			{currentMa, frequencyHz, motorTempC, moduleTempC} = 48'({$random(seed), $random(seed)});
			rotation = rotation_type'(n[1:0]); // every rotation code
			{portDigitalMode, health, measuredSpeed} = 26'($random(seed));
			motorMinSpeed = 16'h0100 + 16'($random(seed) & 16'h00FF);
			motorMaxSpeed = motorMinSpeed + 16'h0200;
			case (n % 5)
				0: commandedSpeed = motorMaxSpeed;
				1: commandedSpeed = motorMaxSpeed + 16'h0001;
				2: commandedSpeed = motorMinSpeed;
				3: commandedSpeed = motorMinSpeed - 16'h0001;
				default: commandedSpeed = 16'($random(seed));
			endcase
			outputShort = 4'($random(seed));
			for (int k = 0; k < 2 * P; k++) outputCurrentMa[k / P][k % P] = 16'd999 + 16'($random(seed) & 3);
			servoFeedback = 34'({$random(seed), $random(seed)});
			servoCommand = 32'($random(seed));
			for (int i = 0; i < 13; i++) begin
				u_plc_host_model.xfer(1'b0, MEAS[i], 16'h0000, rd);
				chk("status word", expect_word(MEAS[i]), rd);
			end
			chk("applied speed", (commandedSpeed > motorMaxSpeed) ? motorMaxSpeed :
				(commandedSpeed < motorMinSpeed) ? motorMinSpeed : commandedSpeed, appliedSpeed);
			// writes are acknowledged with zero data and change nothing
			u_plc_host_model.xfer(1'b1, MEAS[n % 13], $random(seed), rd);
			chk("write answer", 16'h0000, rd);
			u_plc_host_model.xfer(1'b0, MEAS[n % 13], 16'h0000, rd);
			chk("after write", expect_word(MEAS[n % 13]), rd);
		end
		$display("test measurements done");
		// each report combination once, running ones to upstream, stopped ones to downstream; links kept, then links cleared
		for (int n = 0; n < 16; n++) begin
			linksKept = !n[3];
			neighbour(n[0], zone_report_type'(n[2:0] >> 0), $random(seed), $random(seed));
			if (linksKept && n[0]) begin
				upZone = zone_code(zone_report_type'(n[2:0]));
				{trA, trB} = {~upstreamTrackA, ~upstreamTrackB};
			end else if (linksKept) begin
				dnZone = zone_code(zone_report_type'(n[2:0]));
			end
			for (int i = 0; i < 4; i++) begin
				u_plc_host_model.xfer(1'b0, i == 0 ? OFS_UPSTREAM_ZONE_STATE : i == 1 ? OFS_DOWNSTREAM_ZONE_STATE :
					i == 2 ? OFS_UPSTREAM_TRACKING_WORD_A : OFS_UPSTREAM_TRACKING_WORD_B, 16'h0000, rd);
				chk("neighbour word", expect_word(u_plc_host_model.regAddr ^ {ADDR_W{1'b1}}), rd);
			end
		end
		$display("test neighbours done");
		summarize();
	end
endmodule // motor_zone_status_regs_tb
`default_nettype wire
